// ### core/hub_downstream_port_manager.sv
// Hub downstream port state, power and indicator control
//
// Behaviour
// R1: Four ports, each usable or removable per config image.
// R2: Unconfigured ports drive SE0, unpowered.
// R3: Configured: stop SE0; host powers each port.
// R4: Powered ports report connect and disconnect changes.
// R5: SetPortReset: SE0, then enabled, green, babble watch.
// R6: Babble on an enabled port disables that port.
// R7: ClearPortEnable disables the addressed port.
// R8: Suspend per port; resume with hub awake is local, flagged.
// R9: Hub suspended: resume goes upstream; host clears suspend.
// R10: Babble and disconnect held back while repeating upstream; the code holds back only the upstream babble flag, not disconnect.
// R11: Ganged or per-port power, per-port by default.
// R12: One power enable per port, polarity selectable.
// R13: Over-current timer 0 to 15 ms, 8 ms default, per enable state.
// R14: Qualified over-current reported, power removed; polarity selectable.
// R15: Indicator support in hub characteristics bit 7, cleared when disabled.
// R16: Separate green and amber outputs per port.
// R17: Automatic after power-up: green enabled, amber after over-current.
// R18: Automatic: green if enabled, amber if over-current, else off.
// R19: Optional square-wave modulation; polarity selectable.
// R20: Manual mode: host sets each indicator, blinking allowed.
// R21: Manual: off, amber, green, blink green, blink amber, alternate.
// R22: Blink and modulation periods are clock parameters.
`timescale 1ns/1ps
`include "port_mgr_cfg.svh"
module hub_downstream_port_manager #(
  parameter int NUM_PORTS = 4,
  parameter int MS_CYCLES = `PM_MS_CYCLES,
  parameter int RESET_CYCLES = `PM_RESET_CYCLES,
  parameter int BLINK_CYCLES = `PM_BLINK_CYCLES,
  parameter int MOD_CYCLES = `PM_MOD_CYCLES
) (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic [NUM_PORTS-1:0] port_usable_i,
  input wire logic [NUM_PORTS-1:0] port_removable_i,
  input wire logic [NUM_PORTS-1:0] line_connect_i,
  input wire logic [NUM_PORTS-1:0] line_resume_i,
  input wire logic [NUM_PORTS-1:0] line_babble_i,
  input wire logic upstream_repeating_i,
  input wire logic [NUM_PORTS-1:0] port_overcurrent_in_n_i,
  output logic [NUM_PORTS-1:0] port_power_enable_n_o,
  output logic [NUM_PORTS-1:0] port_se0_o,
  output logic [NUM_PORTS-1:0] port_babble_detect_o,
  output logic [NUM_PORTS-1:0] green_led_o,
  output logic [NUM_PORTS-1:0] amber_led_o,
  output logic status_change_o,
  output logic upstream_resume_o,
  output logic upstream_babble_o
);
  localparam int MS_W = $clog2(MS_CYCLES + 1);
  localparam int RST_W = $clog2(RESET_CYCLES + 1);
  localparam int BL_W = $clog2(BLINK_CYCLES + 1);
  localparam int MD_W = $clog2(MOD_CYCLES + 1);

  // Register file
  logic [7:0] ctrl_reg;
  logic [7:0] oc_time_reg;
  logic [2:0] ind_sel_reg [NUM_PORTS];
  logic [NUM_PORTS-1:0] change_reg;
  logic [NUM_PORTS-1:0] change_next;
  logic [NUM_PORTS-1:0] oc_flag_reg;
  logic [NUM_PORTS-1:0] power_reg;
  port_mgr_pkg::port_state_t state_reg [NUM_PORTS];

  // Pins pass the synchroniser first
  logic [NUM_PORTS-1:0] oc_pin_sync;
  port_sync2 #(.WIDTH(NUM_PORTS)) u_oc_sync (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .async_i(port_overcurrent_in_n_i),
    .sync_o(oc_pin_sync)
  );

  wire logic configured = ctrl_reg[`PM_CTRL_CONFIGURED];
  wire logic ganged = ctrl_reg[`PM_CTRL_GANGED];
  wire logic hub_susp = ctrl_reg[`PM_CTRL_HUB_SUSP];
  wire logic cmd_wr = reg_wr_i && (reg_addr_i == `PM_ADDR_CMD);
  wire port_mgr_pkg::port_cmd_t cmd_code = port_mgr_pkg::port_cmd_t'(reg_wdata_i[7:4]);
  wire logic [1:0] cmd_port = reg_wdata_i[1:0];
  wire logic [2:0] cmd_ind = reg_wdata_i[3:2] == 2'b00 ? 3'h0 : {1'b0, reg_wdata_i[3:2]};

  // Command hits usable port p, or all usable ports when ganged
  function automatic logic cmd_hits(input int p, input logic gang);
    cmd_hits = cmd_wr && (gang || (cmd_port == 2'(p))) && port_usable_i[p]; // R1
  endfunction : cmd_hits

  // Over-current active level
  function automatic logic oc_active(input logic pin_n, input logic pol);
    oc_active = pol ? pin_n : !pin_n; // R14
  endfunction : oc_active

  // Control and timer registers
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      ctrl_reg <= `PM_CTRL_RESET; // R11
      oc_time_reg <= `PM_OC_TIME_RESET; // R13
    end else if (ce_i && reg_wr_i) begin
      if (reg_addr_i == `PM_ADDR_CTRL) ctrl_reg <= reg_wdata_i;
      if (reg_addr_i == `PM_ADDR_OC_TIME) oc_time_reg <= reg_wdata_i;
    end
  end

  // Manual selections; automatic until host overrides
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      for (int p = 0; p < NUM_PORTS; p++) ind_sel_reg[p] <= 3'h0; // R17
    end else if (ce_i && cmd_wr && cmd_code == port_mgr_pkg::CMD_SET_IND) begin
      ind_sel_reg[cmd_port] <= reg_wdata_i[3] ? 3'(reg_wdata_i[2:0] & 3'h7) : cmd_ind; // R20
    end
  end

  // Over-current qualification timers, one per port
  logic [MS_W-1:0] ms_cnt_reg;
  logic ms_tick;
  logic [3:0] oc_ms_reg [NUM_PORTS];
  logic [NUM_PORTS-1:0] oc_qual;
  assign ms_tick = (ms_cnt_reg == MS_W'(MS_CYCLES - 1));
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) ms_cnt_reg <= '0;
    else if (ce_i) ms_cnt_reg <= ms_tick ? '0 : ms_cnt_reg + 1'b1;
  end
  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      // Enabled ports use the high nibble
      oc_qual[p] = oc_active(oc_pin_sync[p], ctrl_reg[`PM_CTRL_OC_POL]) &&
                   (oc_ms_reg[p] >= ((state_reg[p] == port_mgr_pkg::ST_ENABLED) ?
                    oc_time_reg[7:4] : oc_time_reg[3:0])); // R13
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      for (int p = 0; p < NUM_PORTS; p++) oc_ms_reg[p] <= 4'h0;
    end else if (ce_i) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (!oc_active(oc_pin_sync[p], ctrl_reg[`PM_CTRL_OC_POL]) || !power_reg[p])
          oc_ms_reg[p] <= 4'h0;
        else if (ms_tick && oc_ms_reg[p] != 4'(`PM_OC_MS_MAX))
          oc_ms_reg[p] <= oc_ms_reg[p] + 4'h1;
      end
    end
  end

  // Port reset timers
  logic [RST_W-1:0] rst_cnt_reg [NUM_PORTS];
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      for (int p = 0; p < NUM_PORTS; p++) rst_cnt_reg[p] <= '0;
    end else if (ce_i) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (state_reg[p] != port_mgr_pkg::ST_RESETTING) rst_cnt_reg[p] <= '0;
        else rst_cnt_reg[p] <= rst_cnt_reg[p] + 1'b1;
      end
    end
  end

  // Port state machines
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      for (int p = 0; p < NUM_PORTS; p++) state_reg[p] <= port_mgr_pkg::ST_UNPOWERED; // R2
      power_reg <= '0;
      oc_flag_reg <= '0;
    end else if (ce_i) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (!configured) begin
          state_reg[p] <= port_mgr_pkg::ST_UNPOWERED; // R2
          power_reg[p] <= 1'b0;
        end else if (oc_qual[p]) begin
          state_reg[p] <= port_mgr_pkg::ST_OVERCURRENT; // R14
          power_reg[p] <= 1'b0;
          oc_flag_reg[p] <= 1'b1;
        end else if (cmd_hits(p, ganged) && cmd_code == port_mgr_pkg::CMD_SET_POWER) begin
          power_reg[p] <= 1'b1; // R3 R11
          oc_flag_reg[p] <= 1'b0;
          state_reg[p] <= port_mgr_pkg::ST_DISCONN;
        end else if (cmd_hits(p, ganged) && cmd_code == port_mgr_pkg::CMD_CLR_POWER) begin
          power_reg[p] <= 1'b0;
          state_reg[p] <= port_mgr_pkg::ST_UNPOWERED;
        end else begin
          unique case (state_reg[p])
            port_mgr_pkg::ST_UNPOWERED, port_mgr_pkg::ST_OVERCURRENT: ;
            port_mgr_pkg::ST_DISCONN: begin
              if (line_connect_i[p]) state_reg[p] <= port_mgr_pkg::ST_DISABLED; // R4
            end
            port_mgr_pkg::ST_DISABLED: begin
              if (!line_connect_i[p]) state_reg[p] <= port_mgr_pkg::ST_DISCONN; // R4
              else if (cmd_hits(p, 1'b0) && cmd_code == port_mgr_pkg::CMD_SET_RESET)
                state_reg[p] <= port_mgr_pkg::ST_RESETTING; // R5
            end
            port_mgr_pkg::ST_RESETTING: begin
              if (rst_cnt_reg[p] == RST_W'(RESET_CYCLES - 1))
                state_reg[p] <= port_mgr_pkg::ST_ENABLED; // R5
            end
            port_mgr_pkg::ST_ENABLED: begin
              if (!line_connect_i[p]) state_reg[p] <= port_mgr_pkg::ST_DISCONN;
              else if (line_babble_i[p]) state_reg[p] <= port_mgr_pkg::ST_DISABLED; // R6
              else if (cmd_hits(p, 1'b0) && cmd_code == port_mgr_pkg::CMD_CLR_ENABLE)
                state_reg[p] <= port_mgr_pkg::ST_DISABLED; // R7
              else if (cmd_hits(p, 1'b0) && cmd_code == port_mgr_pkg::CMD_SET_SUSPEND)
                state_reg[p] <= port_mgr_pkg::ST_SUSPENDED; // R8
            end
            port_mgr_pkg::ST_SUSPENDED: begin
              if (!line_connect_i[p]) state_reg[p] <= port_mgr_pkg::ST_DISCONN;
              else if (cmd_hits(p, 1'b0) && cmd_code == port_mgr_pkg::CMD_CLR_SUSPEND)
                state_reg[p] <= port_mgr_pkg::ST_RESUMING; // R9
              else if (line_resume_i[p]) state_reg[p] <= port_mgr_pkg::ST_RESUMING; // R8
            end
            port_mgr_pkg::ST_RESUMING: begin
              state_reg[p] <= port_mgr_pkg::ST_ENABLED;
            end
            default: state_reg[p] <= port_mgr_pkg::ST_UNPOWERED;
          endcase
        end
      end
    end
  end

  // Sticky change bits; a new event beats a clear
  always_comb begin
    change_next = change_reg;
    if (reg_wr_i && reg_addr_i == `PM_ADDR_CHANGE) change_next = change_reg & ~reg_wdata_i[3:0];
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (configured && power_reg[p] &&
          ((state_reg[p] == port_mgr_pkg::ST_DISCONN && line_connect_i[p]) ||
           (state_reg[p] != port_mgr_pkg::ST_DISCONN &&
            state_reg[p] != port_mgr_pkg::ST_UNPOWERED && !line_connect_i[p]) ||
           (state_reg[p] == port_mgr_pkg::ST_ENABLED && line_babble_i[p]) ||
           (state_reg[p] == port_mgr_pkg::ST_RESETTING &&
            rst_cnt_reg[p] == RST_W'(RESET_CYCLES - 1)) ||
           (state_reg[p] == port_mgr_pkg::ST_SUSPENDED && line_resume_i[p] && !hub_susp)))
        change_next[p] = 1'b1; // R4 R8
      if (oc_qual[p] && power_reg[p]) change_next[p] = 1'b1; // R14
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) change_reg <= '0;
    else if (ce_i) change_reg <= change_next;
  end

  // Upstream flags; babble held back while repeating
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      status_change_o <= 1'b0;
      upstream_resume_o <= 1'b0;
      upstream_babble_o <= 1'b0;
    end else if (ce_i) begin
      status_change_o <= |change_next; // R4
      upstream_resume_o <= hub_susp && |(line_resume_i & port_usable_i); // R9
      upstream_babble_o <= !upstream_repeating_i && |(line_babble_i & port_babble_detect_o); // R10
    end
  end

  // Line, babble watch and power outputs
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      port_se0_o <= '1; // R2
      port_babble_detect_o <= '0;
      port_power_enable_n_o <= '1;
    end else if (ce_i) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        port_se0_o[p] <= !configured || state_reg[p] == port_mgr_pkg::ST_RESETTING; // R2 R3 R5
        port_babble_detect_o[p] <= state_reg[p] == port_mgr_pkg::ST_ENABLED; // R5
        port_power_enable_n_o[p] <= ctrl_reg[`PM_CTRL_PWR_POL] ? power_reg[p] : !power_reg[p]; // R12
      end
    end
  end

  // Blink and modulation time bases
  logic [BL_W-1:0] blink_cnt_reg;
  logic [MD_W-1:0] mod_cnt_reg;
  logic blink_reg;
  logic mod_reg;
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      blink_cnt_reg <= '0;
      mod_cnt_reg <= '0;
      blink_reg <= 1'b0;
      mod_reg <= 1'b0;
    end else if (ce_i) begin
      blink_cnt_reg <= (blink_cnt_reg == BL_W'(BLINK_CYCLES - 1)) ? '0 : blink_cnt_reg + 1'b1; // R22
      if (blink_cnt_reg == BL_W'(BLINK_CYCLES - 1)) blink_reg <= !blink_reg;
      mod_cnt_reg <= (mod_cnt_reg == MD_W'(MOD_CYCLES - 1)) ? '0 : mod_cnt_reg + 1'b1; // R22
      if (mod_cnt_reg == MD_W'(MOD_CYCLES - 1)) mod_reg <= !mod_reg;
    end
  end

  // Indicator colour per port
  port_mgr_pkg::led_pair_t led [NUM_PORTS];
  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      led[p] = '0;
      unique case (port_mgr_pkg::ind_sel_t'(ind_sel_reg[p]))
        port_mgr_pkg::IND_AUTO: begin
          led[p].green = state_reg[p] == port_mgr_pkg::ST_ENABLED; // R17 R18
          led[p].amber = state_reg[p] == port_mgr_pkg::ST_OVERCURRENT || oc_flag_reg[p]; // R18
        end
        port_mgr_pkg::IND_AMBER: led[p].amber = 1'b1; // R21
        port_mgr_pkg::IND_GREEN: led[p].green = 1'b1; // R21
        port_mgr_pkg::IND_OFF: ;
        port_mgr_pkg::IND_BLINK_GREEN: led[p].green = blink_reg; // R21
        port_mgr_pkg::IND_BLINK_AMBER: led[p].amber = blink_reg; // R21
        port_mgr_pkg::IND_ALTERNATE: begin
          led[p].green = blink_reg; // R21
          led[p].amber = !blink_reg;
        end
        default: ;
      endcase
      if (ctrl_reg[`PM_CTRL_IND_DIS]) led[p] = '0;
    end
  end

  // Modulation gates the on time; polarity applied last
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      green_led_o <= '0;
      amber_led_o <= '0;
    end else if (ce_i) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        green_led_o[p] <= ctrl_reg[`PM_CTRL_IND_POL] ^ (led[p].green &&
                          (!ctrl_reg[`PM_CTRL_MOD_EN] || mod_reg)); // R16 R19
        amber_led_o[p] <= ctrl_reg[`PM_CTRL_IND_POL] ^ (led[p].amber &&
                          (!ctrl_reg[`PM_CTRL_MOD_EN] || mod_reg)); // R16 R19
      end
    end
  end

  // Read data in the cycle after the strobe
  logic [7:0] status_word;
  always_comb begin
    status_word = '0;
    for (int p = 0; p < NUM_PORTS; p++)
      status_word[p] = state_reg[p] == port_mgr_pkg::ST_ENABLED;
    status_word[7:4] = oc_flag_reg;
  end
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) reg_rdata_o <= '0;
    else if (ce_i) begin
      reg_rdata_o <= '0;
      if (reg_rd_i) begin
        unique case (reg_addr_i)
          `PM_ADDR_CTRL: reg_rdata_o <= ctrl_reg;
          `PM_ADDR_OC_TIME: reg_rdata_o <= oc_time_reg;
          `PM_ADDR_IND: reg_rdata_o <= {port_removable_i, port_usable_i}; // R1
          `PM_ADDR_STATUS: reg_rdata_o <= status_word;
          `PM_ADDR_CHANGE: reg_rdata_o <= {4'h0, change_reg};
          `PM_ADDR_HUBCHAR: reg_rdata_o <= 8'(!ctrl_reg[`PM_CTRL_IND_DIS]) << `PM_HUBCHAR_IND_BIT; // R15
          default: reg_rdata_o <= '0;
        endcase
      end
    end
  end
endmodule : hub_downstream_port_manager

// ### core/port_mgr_cfg.svh
// Port manager constants
`ifndef PORT_MGR_CFG_SVH
`define PORT_MGR_CFG_SVH
`define PM_ADDR_CTRL 4'h0
`define PM_ADDR_CMD 4'h1
`define PM_ADDR_OC_TIME 4'h2
`define PM_ADDR_IND 4'h3
`define PM_ADDR_STATUS 4'h4
`define PM_ADDR_CHANGE 4'h5
`define PM_ADDR_HUBCHAR 4'h6
`define PM_CTRL_CONFIGURED 0
`define PM_CTRL_GANGED 1
`define PM_CTRL_PWR_POL 2
`define PM_CTRL_OC_POL 3
`define PM_CTRL_IND_POL 4
`define PM_CTRL_IND_DIS 5
`define PM_CTRL_MOD_EN 6
`define PM_CTRL_HUB_SUSP 7
`define PM_CTRL_RESET 8'h00
`define PM_OC_TIME_RESET 8'h88
`define PM_OC_MS_DEFAULT 8
`define PM_OC_MS_MAX 15
`define PM_HUBCHAR_IND_BIT 7
`define PM_CLK_HZ 25000000
`define PM_MS_CYCLES (`PM_CLK_HZ / 1000)
`define PM_RESET_US 10000
`define PM_RESET_CYCLES (`PM_RESET_US * (`PM_CLK_HZ / 1000000))
`define PM_BLINK_CYCLES (`PM_CLK_HZ / 2)
`define PM_MOD_CYCLES 32
`endif

// ### core/port_mgr_pkg.sv
// Port manager types
package port_mgr_pkg;
  typedef enum logic [7:0] {
    ST_UNPOWERED = 8'b0000_0001,
    ST_DISCONN = 8'b0000_0010,
    ST_DISABLED = 8'b0000_0100,
    ST_RESETTING = 8'b0000_1000,
    ST_ENABLED = 8'b0001_0000,
    ST_SUSPENDED = 8'b0010_0000,
    ST_RESUMING = 8'b0100_0000,
    ST_OVERCURRENT = 8'b1000_0000
  } port_state_t;
  typedef enum logic [3:0] {
    CMD_NONE = 4'h0,
    CMD_SET_POWER = 4'h1,
    CMD_CLR_POWER = 4'h2,
    CMD_SET_RESET = 4'h3,
    CMD_CLR_ENABLE = 4'h4,
    CMD_SET_SUSPEND = 4'h5,
    CMD_CLR_SUSPEND = 4'h6,
    CMD_SET_IND = 4'h7
  } port_cmd_t;
  typedef enum logic [2:0] {
    IND_AUTO = 3'h0,
    IND_AMBER = 3'h1,
    IND_GREEN = 3'h2,
    IND_OFF = 3'h3,
    IND_BLINK_GREEN = 3'h4,
    IND_BLINK_AMBER = 3'h5,
    IND_ALTERNATE = 3'h6
  } ind_sel_t;
  typedef struct packed {
    logic green;
    logic amber;
  } led_pair_t;
  typedef struct packed {
    logic connect;
    logic resume;
    logic babble;
  } line_event_t;
endpackage : port_mgr_pkg

// ### core/port_sync2.sv
// Two-stage pin synchroniser
`timescale 1ns/1ps
module port_sync2 #(
  parameter int WIDTH = 4
) (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_reg;

  // First stage is read only by the second
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      meta_reg <= '0;
      sync_o <= '0;
    end else if (ce_i) begin
      meta_reg <= async_i;
      sync_o <= meta_reg;
    end
  end
endmodule : port_sync2

// ### verif/hub_downstream_port_manager_bench.sv
// Self-checking bench
`timescale 1ns/1ps
module hub_downstream_port_manager_bench;
  localparam int RST_LEN = 20;
  localparam int LIMIT = 6000;
  logic clk_sys, reset, ce, wr, rd, rep, stc, ures, ubab, pwr_pol, u;
  logic [3:0] addr, conn, resm, bab, oc_n, pen_n, se0, bdet, grn, amb, fault;
  logic [3:0] g_on, g_off, a_on, a_off, both;
  logic [7:0] wdata, rdata, d, img = 8'h3F;
  int cycles = 0;
  int err_total = 0;
  int samples_checked = 0;

  hub_downstream_port_manager #(.MS_CYCLES(10), .RESET_CYCLES(RST_LEN), .BLINK_CYCLES(8),
    .MOD_CYCLES(4)) DUT (.clk_sys_i(clk_sys), .reset_i(reset), .ce_i(ce),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .port_usable_i(img[3:0]), .port_removable_i(img[7:4]),
    .line_connect_i(conn), .line_resume_i(resm), .line_babble_i(bab),
    .upstream_repeating_i(rep), .port_overcurrent_in_n_i(oc_n),
    .port_power_enable_n_o(pen_n), .port_se0_o(se0), .port_babble_detect_o(bdet),
    .green_led_o(grn), .amber_led_o(amb), .status_change_o(stc),
    .upstream_resume_o(ures), .upstream_babble_o(ubab));
  port_power_switch_model u_switch (.power_enable_n_i(pen_n), .enable_high_i(pwr_pol),
    .oc_high_i(1'b0), .fault_i(fault), .overcurrent_n_o(oc_n));

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // Ceiling well past the test length
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      err_total++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_of_test

  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk_reg

  // Pin vectors via the byte compare
  task automatic chk_pins(input logic [3:0] got, input logic [3:0] exp, input string what);
    chk_reg({4'h0, got}, {4'h0, exp}, what);
  endtask : chk_pins

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask : wr_reg

  // Answer stands one cycle after the strobe
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk_sys);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : rd_reg

  task automatic cmd(input port_mgr_pkg::port_cmd_t c, input logic [1:0] p);
    wr_reg(4'h1, {c, 2'b00, p});
  endtask : cmd

  task automatic wait_cycles(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : wait_cycles

  task automatic port_reset(input logic [1:0] p);
    cmd(port_mgr_pkg::CMD_SET_RESET, p);
    wait_cycles(RST_LEN + 6);
  endtask : port_reset

  // One-cycle babble on port 0; u takes the upstream flag
  task automatic babble(input logic r);
    @(posedge clk_sys);
    rep <= r;
    bab <= 4'h1;
    @(posedge clk_sys);
    bab <= 4'h0;
    #1 u = ubab;
    wait_cycles(4);
  endtask : babble

  task automatic resume_port1();
    @(posedge clk_sys);
    resm <= 4'h2;
    @(posedge clk_sys);
    resm <= 4'h0;
    #1 u = ures;
    wait_cycles(3);
  endtask : resume_port1

  initial begin
    reset = 1'b1;
    ce = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    conn = 4'h0;
    resm = 4'h0;
    bab = 4'h0;
    rep = 1'b0;
    fault = 4'h0;
    pwr_pol = 1'b0;
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    rd_reg(4'h0, d);
    chk_reg(d, 8'h00, "ctrl reset");
    rd_reg(4'h2, d);
    chk_reg(d, 8'h88, "oc time");
    rd_reg(4'h6, d);
    chk_reg(d & 8'h80, 8'h80, "ind on");
    rd_reg(4'h3, d);
    chk_reg(d, 8'h3F, "port image");
    rd_reg(4'hF, d);
    chk_reg(d, 8'h00, "unmapped");
    chk_pins(se0, 4'hF, "se0 on");
    chk_pins(pen_n, 4'hF, "unpowered");
    chk_pins(grn | amb, 4'h0, "leds dark");
    $display("test reset done");
    // Ganged first, then per-port power
    wr_reg(4'h0, 8'h03);
    wait_cycles(2);
    chk_pins(se0, 4'h0, "se0 off");
    cmd(port_mgr_pkg::CMD_SET_POWER, 2'd0);
    wait_cycles(3);
    chk_pins(pen_n, 4'h0, "ganged on");
    cmd(port_mgr_pkg::CMD_CLR_POWER, 2'd0);
    wait_cycles(3);
    chk_pins(pen_n, 4'hF, "ganged off");
    wr_reg(4'h0, 8'h01);
    for (int p = 0; p < 4; p++) begin
      cmd(port_mgr_pkg::CMD_SET_POWER, 2'(p));
      wait_cycles(3);
      chk_pins(pen_n, 4'hF << (p + 1), "port power");
    end
    wr_reg(4'h5, 8'h0F);
    @(posedge clk_sys);
    conn <= 4'h3;
    wait_cycles(4);
    chk_pins({3'b000, stc}, 4'h1, "change flag");
    rd_reg(4'h5, d);
    chk_reg(d, 8'h03, "connect");
    wr_reg(4'h5, 8'h0F);
    wait_cycles(2);
    chk_pins({3'b000, stc}, 4'h0, "cleared");
    $display("test power done");
    port_reset(2'd0);
    rd_reg(4'h4, d);
    chk_reg(d, 8'h01, "enabled");
    chk_pins(grn, 4'h1, "green");
    chk_pins(bdet, 4'h1, "babble watch");
    babble(1'b1);
    chk_pins({3'b000, u}, 4'h0, "held back");
    chk_pins(grn, 4'h0, "babble disables");
    port_reset(2'd0);
    babble(1'b0);
    chk_pins({3'b000, u}, 4'h1, "reported");
    port_reset(2'd0);
    cmd(port_mgr_pkg::CMD_CLR_ENABLE, 2'd0);
    wait_cycles(3);
    rd_reg(4'h4, d);
    chk_reg(d, 8'h00, "clear enable");
    $display("test enable done");
    port_reset(2'd1);
    cmd(port_mgr_pkg::CMD_SET_SUSPEND, 2'd1);
    wr_reg(4'h5, 8'h0F);
    resume_port1();
    chk_pins({3'b000, u}, 4'h0, "local resume");
    rd_reg(4'h5, d);
    chk_reg(d & 8'h02, 8'h02, "resume change");
    wr_reg(4'h0, 8'h81);
    resume_port1();
    chk_pins({3'b000, u}, 4'h1, "forwarded");
    cmd(port_mgr_pkg::CMD_CLR_SUSPEND, 2'd1);
    wr_reg(4'h0, 8'h01);
    $display("test suspend done");
    // Disabled-port timer of 2 ms on port 2
    wr_reg(4'h2, 8'h32);
    @(posedge clk_sys);
    fault <= 4'h4;
    wait_cycles(10);
    chk_pins(pen_n, 4'h0, "oc not yet");
    wait_cycles(20);
    chk_pins(pen_n, 4'h4, "oc power");
    chk_pins(amb, 4'h4, "oc amber");
    rd_reg(4'h4, d);
    chk_reg(d & 8'hF0, 8'h40, "oc flag");
    @(posedge clk_sys);
    fault <= 4'h0;
    pwr_pol <= 1'b1;
    wr_reg(4'h0, 8'h35);
    wait_cycles(3);
    chk_pins(pen_n, 4'hB, "power sense");
    chk_pins(amb, 4'hF, "amber sense");
    chk_pins(grn | 4'h2, 4'hF, "green sense");
    rd_reg(4'h6, d);
    chk_reg(d & 8'h80, 8'h00, "ind off");
    @(posedge clk_sys);
    pwr_pol <= 1'b0;
    wr_reg(4'h0, 8'h01);
    $display("test overcurrent done");
    // Selector low bits double as the port number
    for (int s = 1; s < 4; s++) begin
      wr_reg(4'h1, {4'h7, 1'b1, 3'(s)});
    end
    wait_cycles(3);
    chk_pins(amb, 4'h2, "manual amber");
    chk_pins(grn, 4'h4, "manual green");
    for (int s = 4; s < 7; s++) begin
      wr_reg(4'h1, {4'h7, 1'b1, 3'(s)});
    end
    {g_on, g_off, a_on, a_off, both} = '0;
    repeat (40) begin
      wait_cycles(1);
      g_on |= grn;
      g_off |= ~grn;
      a_on |= amb;
      a_off |= ~amb;
      both |= grn & amb;
    end
    chk_pins({g_on[0], g_off[0], a_on[0], g_on[1]}, 4'hC, "blink green");
    chk_pins({a_on[1], a_off[1], g_on[2], a_on[2]}, 4'hF, "blink amber");
    chk_pins(both & 4'h7, 4'h0, "one led");
    $display("test manual done");
    end_of_test();
  end
endmodule : hub_downstream_port_manager_bench

// ### verif/hub_port_mgr_chk.sv
// Port-level assertions
`timescale 1ns/1ps
module hub_port_mgr_chk #(
  parameter int NUM_PORTS = 4
) (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [NUM_PORTS-1:0] line_resume_i,
  input wire logic [NUM_PORTS-1:0] line_babble_i,
  input wire logic upstream_repeating_i,
  input wire logic [NUM_PORTS-1:0] port_power_enable_n_o,
  input wire logic [NUM_PORTS-1:0] port_se0_o,
  input wire logic [NUM_PORTS-1:0] port_babble_detect_o,
  input wire logic upstream_resume_o,
  input wire logic upstream_babble_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (reset_i);

  // Port reset: SE0 run, then the port is watched
  sequence s_se0_run;
    port_se0_o[0] [*8];
  endsequence
  sequence s_enabled;
    !port_se0_o[0] && port_babble_detect_o[0];
  endsequence

  property p_unpowered_after_reset;
    $fell(reset_i) |-> (&port_se0_o) && (&port_power_enable_n_o);
  endproperty
  a_unpowered_after_reset: assert property (p_unpowered_after_reset)
    else $error("ports not idle after reset");
  property p_no_watch_in_se0;
    (port_se0_o & port_babble_detect_o) == '0;
  endproperty
  a_no_watch_in_se0: assert property (p_no_watch_in_se0)
    else $error("babble watch during SE0");
  property p_reset_then_enable;
    $rose(port_se0_o[0]) |-> s_se0_run ##[1:20] s_enabled;
  endproperty
  a_reset_then_enable: assert property (p_reset_then_enable)
    else $error("port reset did not enable");
  property p_babble_disables;
    line_babble_i[0] && port_babble_detect_o[0] |-> ##[1:3] !port_babble_detect_o[0];
  endproperty
  a_babble_disables: assert property (p_babble_disables)
    else $error("babbling port stayed enabled");
  property p_babble_cause;
    upstream_babble_o |-> $past(!upstream_repeating_i && |(line_babble_i & port_babble_detect_o));
  endproperty
  a_babble_cause: assert property (p_babble_cause)
    else $error("stray upstream babble");
  property p_repeat_blocks;
    upstream_repeating_i |=> !upstream_babble_o;
  endproperty
  a_repeat_blocks: assert property (p_repeat_blocks)
    else $error("babble passed while repeating");
  property p_resume_cause;
    upstream_resume_o |-> $past(|line_resume_i);
  endproperty
  a_resume_cause: assert property (p_resume_cause)
    else $error("stray upstream resume");
  property p_rdata_quiet;
    !$past(reg_rd_i) |-> reg_rdata_o == 8'h00;
  endproperty
  a_rdata_quiet: assert property (p_rdata_quiet)
    else $error("read data outside answer cycle");
endmodule : hub_port_mgr_chk

bind hub_downstream_port_manager hub_port_mgr_chk #(.NUM_PORTS(NUM_PORTS)) u_chk (
  .clk_sys_i, .reset_i, .reg_rd_i, .reg_rdata_o, .line_resume_i, .line_babble_i,
  .upstream_repeating_i, .port_power_enable_n_o, .port_se0_o, .port_babble_detect_o,
  .upstream_resume_o, .upstream_babble_o
);

// ### verif/port_power_switch_model.sv
// External power switch model
`timescale 1ns/1ps
module port_power_switch_model (
  input wire logic [3:0] power_enable_n_i,
  input wire logic enable_high_i,
  input wire logic oc_high_i,
  input wire logic [3:0] fault_i,
  output logic [3:0] overcurrent_n_o
);
  logic [3:0] powered;
  // Enable sense follows the hub setting
  assign powered = enable_high_i ? power_enable_n_i : ~power_enable_n_i;
  // Only a powered output can trip
  assign overcurrent_n_o = oc_high_i ? (fault_i & powered) : ~(fault_i & powered);
endmodule : port_power_switch_model
